// [hdl/sbm_pkg.sv]
// Constants and types shared by the supply brownout and shutdown monitor
package sbm_pkg;

   // Register indices on the serial bus
   localparam logic [7:0] REG_FLAGS         = 8'h00;
   localparam logic [7:0] REG_CTRL          = 8'h01;
   localparam logic [7:0] REG_THRESH        = 8'h02;

   // Reset values
   localparam logic [7:0] CTRL_RESET        = 8'h00;
   localparam logic [7:0] THRESH_RESET      = 8'h00;

   // Event flag bit positions
   localparam int unsigned FLAG_BROWNOUT    = 4;
   localparam int unsigned FLAG_SHUTDOWN    = 5;

   // Control bit positions
   localparam int unsigned CTRL_LATCH_CLEAR = 0;
   localparam int unsigned CTRL_DSG_ON      = 1;
   localparam int unsigned CTRL_CHG_ON      = 2;
   localparam int unsigned CTRL_PRECHARGE_FET_DRIVE_OFF    = 3;

   // Threshold nibble positions
   localparam int unsigned THR_BO_LSB       = 4;
   localparam int unsigned THR_SD_LSB       = 0;

   // Thresholds in millivolts
   localparam logic [15:0] BO_BASE_MV       = 16'h1f27;   // 7975 mV
   localparam logic [15:0] SD_BASE_MV       = 16'h194b;   // 6475 mV
   localparam logic [15:0] THR_STEP_MV      = 16'h012c;   // 300 mV
   localparam logic [15:0] HYST_MV         = 16'h0032;   // 50 mV

   // Serial bus slave address, arbitrary value
   localparam logic [6:0]  DEV_ADDR         = 7'h2a;
   localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
   localparam logic [3:0]  LAST_BIT         = 4'h7;

   // Serial slave states
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_ACK  = 6'h04,
      ST_WR   = 6'h08,
      ST_RD   = 6'h10,
      ST_MACK = 6'h20
   } sbm_state_t;

endpackage

// [hdl/sbm_cmp_if.sv]
// Threshold code and comparator result between top and comparator
`timescale 1ns/100ps
`default_nettype none
interface sbm_cmp_if;
   logic [3:0] code;
   logic       below;

   modport cmp  (input code, output below);
   modport ctrl (output code, input below);
endinterface
`default_nettype wire

// [hdl/sbm_sync2.sv]
// Two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module sbm_sync2 (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Level in and out
   input  wire logic din,
   output var  logic dout
);
   logic meta_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= 1'b0;
         dout   <= 1'b0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule
`default_nettype wire

// [hdl/sbm_hyst_cmp.sv]
// Programmable undervoltage comparator with hysteresis
`timescale 1ns/100ps
`default_nettype none
module sbm_hyst_cmp #(
   parameter logic [15:0] BASE_MV = 16'h0000
) (
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   rst,
   // Sensed voltage in millivolts
   input  wire logic [15:0] sense_mv,
   // Threshold code and result
   sbm_cmp_if.cmp      cmp
);
   import sbm_pkg::*;

   logic [15:0] thr_mv;
   logic [15:0] rel_mv;
   logic        below_r;
   logic        below_nxt;

   // Linear decode, code 0 is the base value
   assign thr_mv    = 16'(BASE_MV + 16'(cmp.code) * THR_STEP_MV);
   // Sets on falling crossing, releases above threshold plus hysteresis
   assign rel_mv    = 16'(thr_mv + HYST_MV);
   assign below_nxt = (sense_mv < thr_mv) ? 1'b1 :
                      (sense_mv > rel_mv) ? 1'b0 : below_r;
   assign cmp.below = below_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         below_r <= 1'b0;
      end else begin
         below_r <= below_nxt;
      end
   end
endmodule
`default_nettype wire

// [hdl/sbm_monitor.sv]
// Supply brownout and shutdown monitor with serial register access
//
// Functional notes
// - Brownout sets flag bit 4, asserts alert
// - Upper nibble selects brownout threshold, default lowest
// - Status read releases alert, flag stays set
// - Flag clears after latch-clear pulse then read
// - Lower nibble selects shutdown threshold, default lowest
// - Below shutdown, pack not above battery: flag bit 5
// - Shutdown enters sleep, forces all FETs off
// - Shutdown flag clears itself when voltage recovers
// - Shutdown never asserts the alert
// - Both comparators have 50 mV hysteresis
// - FET drives only while enable input low
// - Alert is open-drain, driven low on brownout entry
// - Host FET control ignored during shutdown
`timescale 1ns/100ps
`default_nettype none
module sbm_monitor (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   // Measured voltages in millivolts
   input  wire logic [15:0] BAT_SENSE_MV,
   input  wire logic [15:0] PACK_VOLTAGE_IN_MV,
   // Two-wire serial bus
   input  wire logic        SCLK_I,
   output var  logic        SCLK_O,
   output var  logic        SCLK_OE,
   input  wire logic        SDATA_I,
   output var  logic        SDATA_O,
   output var  logic        SDATA_OE,
   // FET control
   input  wire logic        FET_ENABLE_N,
   output var  logic        CHARGE_FET_DRIVE,
   output var  logic        DISCHARGE_FET_DRIVE,
   output var  logic        PRECHARGE_FET_DRIVE,
   // Status
   output var  logic        ALERT_OUT_N_O,
   output var  logic        ALERT_OUT_N_OE,
   output var  logic        SLEEP_MODE
);
   import sbm_pkg::*;

   // Register file
   logic [7:0]  ctrl_r;
   logic [7:0]  thresh_r;
   logic [7:0]  flags;
   logic [7:0]  rd_mux;

   // Supervision state
   logic        bo_below_s;
   logic        sd_below_s;
   logic        bo_below_q_r;
   logic        bo_rise;
   logic        bo_flag_r;
   logic        bo_flag_nxt;
   logic        sd_flag_r;
   logic        sd_flag_nxt;
   logic        pack_higher;
   logic        alert_r;
   logic        alert_nxt;
   logic        clr_prev_r;
   logic        clr_seen_r;
   logic        clr_armed_r;
   logic        clr_rise;
   logic        clr_fall;
   logic        clr_fire;
   logic        fet_ok;

   // Serial slave state
   sbm_state_t  state_r;
   sbm_state_t  state_nxt;
   logic [3:0]  cnt_r;
   logic [3:0]  cnt_nxt;
   logic [7:0]  shreg_r;
   logic [7:0]  shreg_nxt;
   logic [7:0]  ptr_r;
   logic [7:0]  ptr_nxt;
   logic        ptr_phase_r;
   logic        ptr_phase_nxt;
   logic        rw_r;
   logic        rw_nxt;
   logic        acked_r;
   logic        acked_nxt;
   logic        sda_oe_r;
   logic        sda_oe_nxt;
   logic        wr_en;
   logic        status_rd;
   logic        scl_q_r;
   logic        sda_q_r;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;

   sbm_cmp_if bo_if ();
   sbm_cmp_if sd_if ();

   assign bo_if.code = thresh_r[THR_BO_LSB +: 4];
   assign sd_if.code = thresh_r[THR_SD_LSB +: 4];

   sbm_hyst_cmp #(
      .BASE_MV (BO_BASE_MV)
   ) u_bo_cmp (
      .clk      (SYS_CLK),
      .rst      (RST),
      .sense_mv (BAT_SENSE_MV),
      .cmp      (bo_if.cmp)
   );

   sbm_hyst_cmp #(
      .BASE_MV (SD_BASE_MV)
   ) u_sd_cmp (
      .clk      (SYS_CLK),
      .rst      (RST),
      .sense_mv (BAT_SENSE_MV),
      .cmp      (sd_if.cmp)
   );

   // Comparator outputs behave like asynchronous analog levels
   sbm_sync2 u_bo_sync (
      .clk  (SYS_CLK),
      .rst  (RST),
      .din  (bo_if.below),
      .dout (bo_below_s)
   );

   sbm_sync2 u_sd_sync (
      .clk  (SYS_CLK),
      .rst  (RST),
      .din  (sd_if.below),
      .dout (sd_below_s)
   );

   // Brownout flag, set wins over the clear
   assign bo_rise     = bo_below_s & ~bo_below_q_r;
   assign bo_flag_nxt = bo_below_s | (bo_flag_r & ~clr_fire);

   // Latch-clear must go 0, 1, 0 and then a status read follows
   assign clr_rise    = ctrl_r[CTRL_LATCH_CLEAR] & ~clr_prev_r;
   assign clr_fall    = ~ctrl_r[CTRL_LATCH_CLEAR] & clr_prev_r;
   assign clr_fire    = clr_armed_r & status_rd;

   // Alert follows brownout only; a status read releases it
   assign alert_nxt   = bo_rise | (alert_r & ~status_rd);

   // Shutdown is a live level, no host action needed to clear it
   assign pack_higher = PACK_VOLTAGE_IN_MV > BAT_SENSE_MV;
   assign sd_flag_nxt = sd_below_s & ~pack_higher;

   assign fet_ok      = ~FET_ENABLE_N & ~sd_flag_r;

   assign flags = {2'b00, sd_flag_r, bo_flag_r, 4'h0};
   assign rd_mux = (ptr_r == REG_FLAGS)  ? flags :
                   (ptr_r == REG_CTRL)   ? ctrl_r :
                   (ptr_r == REG_THRESH) ? thresh_r : 8'h00;

   // Bus pins are sampled as synchronous inputs
   assign scl_rise  = SCLK_I & ~scl_q_r;
   assign scl_fall  = ~SCLK_I & scl_q_r;
   assign bus_start = SCLK_I & scl_q_r & sda_q_r & ~SDATA_I;
   assign bus_stop  = SCLK_I & scl_q_r & ~sda_q_r & SDATA_I;

   always_comb begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      shreg_nxt     = shreg_r;
      ptr_nxt       = ptr_r;
      ptr_phase_nxt = ptr_phase_r;
      rw_nxt        = rw_r;
      acked_nxt     = acked_r;
      sda_oe_nxt    = sda_oe_r;
      wr_en         = 1'b0;
      status_rd     = 1'b0;
      case (state_r)
         ST_IDLE: begin
            sda_oe_nxt = 1'b0;
         end
         ST_ADDR: begin
            if (scl_rise) begin
               shreg_nxt = {shreg_r[6:0], SDATA_I};
               cnt_nxt   = 4'(cnt_r + 4'h1);
            end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
               if (shreg_r[7:1] == DEV_ADDR) begin
                  sda_oe_nxt    = 1'b1;
                  rw_nxt        = shreg_r[0];
                  ptr_phase_nxt = ~shreg_r[0];
                  state_nxt     = ST_ACK;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_ACK: begin
            if (scl_fall) begin
               cnt_nxt = 4'h0;
               if (rw_r) begin
                  shreg_nxt  = rd_mux;
                  sda_oe_nxt = ~rd_mux[7];
                  status_rd  = (ptr_r == REG_FLAGS);
                  ptr_nxt    = 8'(ptr_r + 8'h01);
                  state_nxt  = ST_RD;
               end else begin
                  sda_oe_nxt = 1'b0;
                  state_nxt  = ST_WR;
               end
            end
         end
         ST_WR: begin
            if (scl_rise) begin
               shreg_nxt = {shreg_r[6:0], SDATA_I};
               cnt_nxt   = 4'(cnt_r + 4'h1);
            end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
               if (ptr_phase_r) begin
                  ptr_nxt       = shreg_r;
                  ptr_phase_nxt = 1'b0;
               end else begin
                  wr_en   = 1'b1;
                  ptr_nxt = 8'(ptr_r + 8'h01);
               end
               sda_oe_nxt = 1'b1;
               state_nxt  = ST_ACK;
            end
         end
         ST_RD: begin
            if (scl_fall) begin
               if (cnt_r == LAST_BIT) begin
                  sda_oe_nxt = 1'b0;
                  state_nxt  = ST_MACK;
               end else begin
                  shreg_nxt  = {shreg_r[6:0], 1'b0};
                  sda_oe_nxt = ~shreg_r[6];
                  cnt_nxt    = 4'(cnt_r + 4'h1);
               end
            end
         end
         ST_MACK: begin
            if (scl_rise) begin
               acked_nxt = ~SDATA_I;
            end else if (scl_fall) begin
               if (acked_r) begin
                  cnt_nxt    = 4'h0;
                  shreg_nxt  = rd_mux;
                  sda_oe_nxt = ~rd_mux[7];
                  status_rd  = (ptr_r == REG_FLAGS);
                  ptr_nxt    = 8'(ptr_r + 8'h01);
                  state_nxt  = ST_RD;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt  = ST_IDLE;
            sda_oe_nxt = 1'b0;
         end
      endcase
      // Start and stop win over any byte in flight
      if (bus_stop) begin
         state_nxt  = ST_IDLE;
         sda_oe_nxt = 1'b0;
      end
      if (bus_start) begin
         state_nxt  = ST_ADDR;
         cnt_nxt    = 4'h0;
         sda_oe_nxt = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state_r     <= ST_IDLE;
         cnt_r       <= 4'h0;
         shreg_r     <= 8'h00;
         ptr_r       <= 8'h00;
         ptr_phase_r <= 1'b0;
         rw_r        <= 1'b0;
         acked_r     <= 1'b0;
         sda_oe_r    <= 1'b0;
         scl_q_r     <= 1'b1;
         sda_q_r     <= 1'b1;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         shreg_r     <= shreg_nxt;
         ptr_r       <= ptr_nxt;
         ptr_phase_r <= ptr_phase_nxt;
         rw_r        <= rw_nxt;
         acked_r     <= acked_nxt;
         sda_oe_r    <= sda_oe_nxt;
         scl_q_r     <= SCLK_I;
         sda_q_r     <= SDATA_I;
      end
   end

   // Register writes; the flag register is read only
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ctrl_r   <= CTRL_RESET;
         thresh_r <= THRESH_RESET;
      end else if (wr_en && ptr_r == REG_CTRL) begin
         ctrl_r   <= shreg_r;
      end else if (wr_en && ptr_r == REG_THRESH) begin
         thresh_r <= shreg_r;
      end
   end

   // Latch-clear sequence tracking
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         clr_prev_r  <= 1'b0;
         clr_seen_r  <= 1'b0;
         clr_armed_r <= 1'b0;
      end else begin
         clr_prev_r  <= ctrl_r[CTRL_LATCH_CLEAR];
         clr_seen_r  <= clr_rise | (clr_seen_r & ~clr_fall);
         clr_armed_r <= (clr_fall & clr_seen_r) | (clr_armed_r & ~status_rd);
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         bo_below_q_r <= 1'b0;
         bo_flag_r    <= 1'b0;
         sd_flag_r    <= 1'b0;
         alert_r      <= 1'b0;
      end else begin
         bo_below_q_r <= bo_below_s;
         bo_flag_r    <= bo_flag_nxt;
         sd_flag_r    <= sd_flag_nxt;
         alert_r      <= alert_nxt;
      end
   end

   // Registered pin drivers; open-drain pins only ever pull low
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         SCLK_O              <= 1'b0;
         SCLK_OE             <= 1'b0;
         SDATA_O             <= 1'b0;
         SDATA_OE            <= 1'b0;
         CHARGE_FET_DRIVE    <= 1'b0;
         DISCHARGE_FET_DRIVE <= 1'b0;
         PRECHARGE_FET_DRIVE <= 1'b0;
         ALERT_OUT_N_O       <= 1'b0;
         ALERT_OUT_N_OE      <= 1'b0;
         SLEEP_MODE          <= 1'b0;
      end else begin
         SCLK_O              <= 1'b0;
         SCLK_OE             <= 1'b0;
         SDATA_O             <= 1'b0;
         SDATA_OE            <= sda_oe_nxt;
         CHARGE_FET_DRIVE    <= fet_ok & ctrl_r[CTRL_CHG_ON];
         DISCHARGE_FET_DRIVE <= fet_ok & ctrl_r[CTRL_DSG_ON];
         PRECHARGE_FET_DRIVE <= fet_ok & ~ctrl_r[CTRL_PRECHARGE_FET_DRIVE_OFF];
         ALERT_OUT_N_O       <= 1'b0;
         ALERT_OUT_N_OE      <= alert_nxt;
         SLEEP_MODE          <= sd_flag_nxt;
      end
   end
endmodule
`default_nettype wire

// [bench/sbm_chk_monitor.sv]
// Port-level assertions for the supply monitor
`timescale 1ns/100ps
`default_nettype none
module sbm_chk
   import sbm_pkg::*;
(
   // Clock and reset
   input wire logic        SYS_CLK,
   input wire logic        RST,
   // Voltages
   input wire logic [15:0] BAT_SENSE_MV,
   input wire logic [15:0] PACK_VOLTAGE_IN_MV,
   // Serial bus
   input wire logic        SCLK_I,
   input wire logic        SCLK_O,
   input wire logic        SCLK_OE,
   input wire logic        SDATA_I,
   input wire logic        SDATA_O,
   input wire logic        SDATA_OE,
   // FETs and status
   input wire logic        FET_ENABLE_N,
   input wire logic        CHARGE_FET_DRIVE,
   input wire logic        DISCHARGE_FET_DRIVE,
   input wire logic        PRECHARGE_FET_DRIVE,
   input wire logic        ALERT_OUT_N_O,
   input wire logic        ALERT_OUT_N_OE,
   input wire logic        SLEEP_MODE
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   logic        fet_any;
   logic [15:0] sd_top_mv;
   assign fet_any   = CHARGE_FET_DRIVE | DISCHARGE_FET_DRIVE | PRECHARGE_FET_DRIVE;
   // Highest shutdown threshold plus hysteresis
   assign sd_top_mv = 16'(SD_BASE_MV + 16'h000f * THR_STEP_MV + HYST_MV);
   // Long quiet window so earlier changes have left the synchroniser
   sequence quiet_s;
      $stable(BAT_SENSE_MV) && $stable(PACK_VOLTAGE_IN_MV);
   endsequence
   // Pack comparison acts at once, so only a step with no pack voltage isolates the sync delay
   sequence step_s;
      quiet_s [*6] ##1 ($changed(BAT_SENSE_MV) && $stable(PACK_VOLTAGE_IN_MV)
                        && PACK_VOLTAGE_IN_MV == 16'h0000);
   endsequence
   AST_FET_GATE: assert property (FET_ENABLE_N |=> !fet_any)
      else $error("fet drive on while enable high");
   AST_SLEEP_FET: assert property (SLEEP_MODE && $past(SLEEP_MODE) |-> !fet_any)
      else $error("fet drive on during sleep");
   AST_ALERT_OD: assert property (ALERT_OUT_N_O == 1'b0)
      else $error("alert driven high");
   AST_BUS_LOW: assert property (!SCLK_OE && !SCLK_O && !SDATA_O)
      else $error("bus line driven wrongly");
   AST_SDA_STEADY: assert property ($changed(SDATA_OE) |-> !SCLK_I)
      else $error("data changed while clock high");
   AST_SETTLE: assert property (step_s |=> $stable(SLEEP_MODE))
      else $error("sleep reacted without synchroniser delay");
   AST_SLEEP_LOW: assert property (
      (BAT_SENSE_MV < SD_BASE_MV && PACK_VOLTAGE_IN_MV <= BAT_SENSE_MV) [*8] |-> SLEEP_MODE)
      else $error("no sleep below lowest threshold");
   AST_PACK_WAKE: assert property ((PACK_VOLTAGE_IN_MV > BAT_SENSE_MV) [*8] |-> !SLEEP_MODE)
      else $error("sleep with higher pack voltage");
   AST_HIGH_WAKE: assert property ((BAT_SENSE_MV > sd_top_mv) [*8] |-> !SLEEP_MODE)
      else $error("sleep above highest threshold");
endmodule
`default_nettype wire

// [bench/sbm_host.sv]
// Behavioural two-wire bus host for the supply monitor
`timescale 1ns/100ps
`default_nettype none
module sbm_host (
   // Clock
   input  wire logic clk,
   // Bus lines, open drain
   output var  logic scl,
   output var  logic sda_o,
   input  wire logic sda
);
   import sbm_pkg::*;
   logic [7:0] nacks;
   logic       r;
   initial begin
      scl = 1'b1;
      sda_o = 1'b1;
      nacks = 8'h00;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Data moves only well inside clock low
   task automatic bit_io(input logic b, output logic q);
      hold(2);
      sda_o = b;
      hold(3);
      scl = 1'b1;
      hold(5);
      q = sda;
      scl = 1'b0;
   endtask
   task automatic start;
      hold(2);
      sda_o = 1'b1;
      hold(3);
      scl = 1'b1;
      hold(5);
      sda_o = 1'b0;
      hold(5);
      scl = 1'b0;
   endtask
   task automatic stop;
      hold(2);
      sda_o = 1'b0;
      hold(3);
      scl = 1'b1;
      hold(5);
      sda_o = 1'b1;
      hold(5);
   endtask
   task automatic tx(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      if (r !== 1'b0) nacks = nacks + 8'h01;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start;
      tx({DEV_ADDR, 1'b0});
      tx(a);
      tx(d);
      stop;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      start;
      tx({DEV_ADDR, 1'b0});
      tx(a);
      start;
      tx({DEV_ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, r);
      stop;
   endtask
   // Two-byte read; master acknowledges the first byte
   task automatic rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
      start;
      tx({DEV_ADDR, 1'b0});
      tx(a);
      start;
      tx({DEV_ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d0[i]);
      bit_io(1'b0, r);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d1[i]);
      bit_io(1'b1, r);
      stop;
   endtask
endmodule
`default_nettype wire

// [bench/sbm_monitor_tb.sv]
// Self-checking bench for the supply monitor
`timescale 1ns/100ps
`default_nettype none
module sbm_monitor_tb;
   import sbm_pkg::*;
   logic        sys_clk, rst, fet_en_n, h_scl, h_sda;
   logic        sclk_o, sclk_oe, sdata_o, sdata_oe, charge_fet_drive, discharge_fet_drive, precharge_fet_drive, al_o, al_oe, sleep;
   logic [15:0] bat, pack;
   logic [7:0]  d, d2;
   logic [3:0]  cb, cs;
   wire logic   scl_w = h_scl & !sclk_oe;
   wire logic   sda_w = h_sda & !sdata_oe;
   int          err_total, n_tests, seed;
   int          cyc = 0;

   sbm_monitor i_sbm_monitor (.SYS_CLK(sys_clk), .RST(rst), .BAT_SENSE_MV(bat),
      .PACK_VOLTAGE_IN_MV(pack), .SCLK_I(scl_w), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe),
      .SDATA_I(sda_w), .SDATA_O(sdata_o), .SDATA_OE(sdata_oe), .FET_ENABLE_N(fet_en_n),
      .CHARGE_FET_DRIVE(charge_fet_drive), .DISCHARGE_FET_DRIVE(discharge_fet_drive), .PRECHARGE_FET_DRIVE(precharge_fet_drive),
      .ALERT_OUT_N_O(al_o), .ALERT_OUT_N_OE(al_oe), .SLEEP_MODE(sleep));
   sbm_host i_sbm_host (.clk(sys_clk), .scl(h_scl), .sda_o(h_sda), .sda(sda_w));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   function automatic logic [15:0] bo_thr(input logic [3:0] c);
      return BO_BASE_MV + 16'(c) * THR_STEP_MV;
   endfunction
   function automatic logic [15:0] sd_thr(input logic [3:0] c);
      return SD_BASE_MV + 16'(c) * THR_STEP_MV;
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chk({7'h00, g}, {7'h00, e});
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Run is about 11.3k cycles; ceiling leaves margin
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         test_done;
      end
   end

   initial begin
      seed = 17;
      err_total = 0;
      n_tests = 0;
      rst = 1'b1;
      bat = 16'h3a98;
      pack = 16'h0000;
      fet_en_n = 1'b1;
      wt(4);
      rst = 1'b0;
      wt(2);
      i_sbm_host.rd(REG_THRESH, d); chk(d, THRESH_RESET);
      i_sbm_host.rd(REG_CTRL, d); chk(d, CTRL_RESET);
      i_sbm_host.wr(REG_FLAGS, 8'hff);
      i_sbm_host.rd(REG_FLAGS, d); chk(d, 8'h00);
      i_sbm_host.rd(8'h07, d); chk(d, 8'h00);
      // Foreign address must be refused without acknowledge
      i_sbm_host.start;
      i_sbm_host.tx({~DEV_ADDR, 1'b0});
      i_sbm_host.stop;
      chk({5'h00, charge_fet_drive, discharge_fet_drive, precharge_fet_drive}, 8'h00);
      $display("test reset done");
      fet_en_n = 1'b0;
      i_sbm_host.wr(REG_CTRL, 8'h06); wt(3); chk({5'h00, charge_fet_drive, discharge_fet_drive, precharge_fet_drive}, 8'h07);
      i_sbm_host.wr(REG_CTRL, 8'h08); wt(3); chk({5'h00, charge_fet_drive, discharge_fet_drive, precharge_fet_drive}, 8'h00);
      i_sbm_host.wr(REG_CTRL, 8'h06);
      fet_en_n = 1'b1;
      wt(3); chk({5'h00, charge_fet_drive, discharge_fet_drive, precharge_fet_drive}, 8'h00);
      fet_en_n = 1'b0;
      $display("test fet done");
      cb = 4'($random(seed));
      i_sbm_host.wr(REG_THRESH, {cb, 4'h0});
      i_sbm_host.rd2(REG_CTRL, d, d2); chk(d, 8'h06);
      chk(d2, {cb, 4'h0});
      bat = bo_thr(cb);
      wt(10); chkb(al_oe, 1'b0);
      bat = bo_thr(cb) - 16'h0001;
      wt(10); chkb(al_oe, 1'b1);
      i_sbm_host.rd(REG_FLAGS, d); chk(d, 8'h10);
      chkb(al_oe, 1'b0);
      bat = bo_thr(cb) + 16'h0033;
      wt(10);
      i_sbm_host.rd(REG_FLAGS, d); chk(d, 8'h10);
      i_sbm_host.wr(REG_CTRL, 8'h07);
      i_sbm_host.wr(REG_CTRL, 8'h06);
      i_sbm_host.rd(REG_FLAGS, d); chk(d, 8'h10);
      i_sbm_host.rd(REG_FLAGS, d); chk(d, 8'h00);
      $display("test brownout done");
      i_sbm_host.wr(REG_THRESH, 8'h00);
      bat = 16'h1edc;
      wt(10); chkb(al_oe, 1'b1);
      i_sbm_host.rd(REG_FLAGS, d); chk(d, 8'h10);
      for (int i = 0; i < 4; i++) begin
         cs = (i == 0) ? 4'h0 : 4'($unsigned($random(seed)) % 5);
         i_sbm_host.wr(REG_THRESH, {4'h0, cs});
         bat = sd_thr(cs) - 16'h0001;
         wt(10); chk({4'h0, sleep, charge_fet_drive, discharge_fet_drive, precharge_fet_drive}, 8'h08);
         chkb(al_oe, 1'b0);
         i_sbm_host.rd(REG_FLAGS, d); chk(d, 8'h30);
         pack = bat + 16'h0001;
         wt(10); chkb(sleep, 1'b0);
         pack = 16'h0000;
         bat = sd_thr(cs) + 16'h0031;
         wt(10); chkb(sleep, 1'b1);
         bat = sd_thr(cs) + 16'h0033;
         wt(10); chkb(sleep, 1'b0);
         i_sbm_host.rd(REG_FLAGS, d); chk(d, 8'h10);
      end
      chk(i_sbm_host.nacks, 8'h01);
      $display("test shutdown done");
      test_done;
   end
endmodule

bind sbm_monitor sbm_chk i_sbm_chk (.SYS_CLK(SYS_CLK), .RST(RST), .BAT_SENSE_MV(BAT_SENSE_MV),
   .PACK_VOLTAGE_IN_MV(PACK_VOLTAGE_IN_MV), .SCLK_I(SCLK_I), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE),
   .SDATA_I(SDATA_I), .SDATA_O(SDATA_O), .SDATA_OE(SDATA_OE), .FET_ENABLE_N(FET_ENABLE_N),
   .CHARGE_FET_DRIVE(CHARGE_FET_DRIVE), .DISCHARGE_FET_DRIVE(DISCHARGE_FET_DRIVE),
   .PRECHARGE_FET_DRIVE(PRECHARGE_FET_DRIVE), .ALERT_OUT_N_O(ALERT_OUT_N_O),
   .ALERT_OUT_N_OE(ALERT_OUT_N_OE), .SLEEP_MODE(SLEEP_MODE));
`default_nettype wire
